// ### inc/bwg_map.svh
/*
 Register indices, field positions, reset values and counts of the
 buzzer waveform generator. Assumes includers add the bwg_ prefix space.
*/
`ifndef BWG_MAP_SVH
`define BWG_MAP_SVH

// word indices; byte address is four times the index
`define BWG_IDX_DIV    30'h0000A128
`define BWG_IDX_FRAME  30'h0000A129
`define BWG_IDX_TOTAL  30'h0000A12A
`define BWG_IDX_CTRL   30'h0000A12B
`define BWG_IDX_MUTE   30'h0000A12C
`define BWG_IDX_STAT   30'h0000A130
`define BWG_IDX_MASK   30'h0000A131

`define BWG_RST_DIV    8'h10
`define BWG_RST_FRAME  8'hF0
`define BWG_RST_TOTAL  8'h80
`define BWG_RST_CTRL   8'h00
`define BWG_RST_MUTE   8'hFF

// tone_control bit positions
`define BWG_CTRL_LAUNCH 0
`define BWG_CTRL_FLAG   1

`define BWG_FIRST_FRAME 8'h01
`define BWG_RESP_OKAY   2'b00
`define BWG_RESP_SLVERR 2'b10

`endif

// ### inc/bwg_pkg.sv
/*
 Types of the buzzer waveform generator.
 Assumes bwg_map.svh supplies the numeric constants.
*/
package bwg_pkg;

    typedef enum logic {
        BWG_IDLE,
        BWG_RUN
    } bwg_state_t;

    // writable part of tone_control, bits 7 down to 2
    typedef struct packed {
        logic on;
        logic irq_en;
        logic clk_pick;
        logic div_hi;
        logic inversion;
        logic repeat_on;
    } bwg_ctrl_t;

endpackage

// ### src/bwg_top.sv
/*
 Buzzer waveform generator with an AXI4-Lite register slave.
 Assumes tone_tick_slow and tone_tick_fast are one-cycle strobes
 synchronous to aclk that stand for the two selectable tone sources.
*/
// The implementer's own choice: the AXI4-Lite slave port.
// Summary of operation
// - The tone toggles every divider+1 source ticks, giving src/(div+1)/2.
// - A frame is the sounding pulses followed by silent pulse periods.
// - frame_pulse_counts holds sounding count high, silent count low.
// - A session lasts session_frame_total frames.
// - Writing one to the launch bit outputs exactly one session.
// - With repeat_sessions set, sessions follow back to back.
// - With the irq enable set, every session end raises the done flag.
// - The generator works only while tone_unit_on is one.
// - Frames whose index exceeds mute_after_frame are silent.
`timescale 1ns/100ps
`include "bwg_map.svh"

module bwg_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic tone_tick_slow,
    input wire logic tone_tick_fast,
    output logic tone_out,
    output logic irq
);

    logic aw_full_reg;
    logic w_full_reg;
    logic [29:0] waddr_reg;
    logic [7:0] wdata_reg;
    logic wstrb0_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [1:0] rresp_reg;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic rhit;
    logic wr_fire;
    logic wr_en;
    logic whit;

    logic [7:0] div_lo_reg;
    logic [7:0] frame_reg;
    logic [7:0] total_reg;
    logic [7:0] mute_reg;
    bwg_pkg::bwg_ctrl_t ctrl_reg;
    logic flag_reg;
    logic mask_reg;
    logic launch_reg;

    bwg_pkg::bwg_state_t state_reg;
    logic [8:0] div_cnt_reg;
    logic half_reg;
    logic [4:0] pcount_reg;
    logic [7:0] frame_cnt_reg;

    logic [8:0] divisor;
    logic tick;
    logic pulse_end;
    logic [4:0] frame_len;
    logic frame_end;
    logic frame_last;
    logic sess_end;
    logic sounding;
    logic muted;
    logic tone_raw;
    logic busy;
    logic flag_clr;

    // write channel: address and data are taken independently
    assign s_axi_awready = !aw_full_reg;
    assign s_axi_wready = !w_full_reg;
    assign wr_fire = aw_full_reg && w_full_reg && !bvalid_reg;
    assign wr_en = wr_fire && wstrb0_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'b0;
            waddr_reg <= 30'h00000000;
        end else if (s_axi_awvalid && !aw_full_reg) begin
            aw_full_reg <= 1'b1;
            waddr_reg <= s_axi_awaddr[31:2];
        end else if (wr_fire) begin
            aw_full_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_reg <= 1'b0;
            wdata_reg <= 8'h00;
            wstrb0_reg <= 1'b0;
        end else if (s_axi_wvalid && !w_full_reg) begin
            w_full_reg <= 1'b1;
            wdata_reg <= s_axi_wdata[7:0];
            wstrb0_reg <= s_axi_wstrb[0];
        end else if (wr_fire) begin
            w_full_reg <= 1'b0;
        end
    end

    always_comb begin
        whit = 1'b0;
        unique case (waddr_reg)
            `BWG_IDX_DIV, `BWG_IDX_FRAME, `BWG_IDX_TOTAL, `BWG_IDX_CTRL,
            `BWG_IDX_MUTE, `BWG_IDX_STAT, `BWG_IDX_MASK: whit = 1'b1;
            default: whit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= `BWG_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= whit ? `BWG_RESP_OKAY : `BWG_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;

    // configuration registers; only byte lane 0 carries data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_lo_reg <= `BWG_RST_DIV;
            frame_reg <= `BWG_RST_FRAME;
            total_reg <= `BWG_RST_TOTAL;
            mute_reg <= `BWG_RST_MUTE;
            ctrl_reg <= bwg_pkg::bwg_ctrl_t'(6'(`BWG_RST_CTRL >> 2));
            mask_reg <= 1'b0;
        end else if (wr_en) begin
            unique case (waddr_reg)
                `BWG_IDX_DIV: div_lo_reg <= wdata_reg;
                `BWG_IDX_FRAME: frame_reg <= wdata_reg;
                `BWG_IDX_TOTAL: total_reg <= wdata_reg;
                `BWG_IDX_MUTE: mute_reg <= wdata_reg;
                `BWG_IDX_CTRL: ctrl_reg <= wdata_reg[7:2];
                `BWG_IDX_MASK: mask_reg <= wdata_reg[0];
                default: ;
            endcase
        end
    end

    // launch bit is a command, never stored as configuration
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            launch_reg <= 1'b0;
        end else begin
            launch_reg <= wr_en && waddr_reg == `BWG_IDX_CTRL &&
                wdata_reg[`BWG_CTRL_LAUNCH];
        end
    end

    // the flag clears from tone_control bit 1 or the status word
    assign flag_clr = wr_en && wdata_reg[`BWG_CTRL_FLAG - 1 + 1] &&
        waddr_reg == `BWG_IDX_CTRL ||
        wr_en && wdata_reg[0] && waddr_reg == `BWG_IDX_STAT;

    // a session end in the clearing cycle wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag_reg <= 1'b0;
        end else if (sess_end && ctrl_reg.irq_en) begin
            flag_reg <= 1'b1;
        end else if (flag_clr) begin
            flag_reg <= 1'b0;
        end
    end

    assign irq = flag_reg && mask_reg;

    // read channel
    assign s_axi_arready = !rvalid_reg;
    assign busy = state_reg == bwg_pkg::BWG_RUN;

    always_comb begin
        rdata_next = 32'h00000000;
        rhit = 1'b1;
        unique case (s_axi_araddr[31:2])
            `BWG_IDX_DIV: rdata_next[7:0] = div_lo_reg;
            `BWG_IDX_FRAME: rdata_next[7:0] = frame_reg;
            `BWG_IDX_TOTAL: rdata_next[7:0] = total_reg;
            `BWG_IDX_MUTE: rdata_next[7:0] = mute_reg;
            `BWG_IDX_CTRL: rdata_next[7:0] = {ctrl_reg, flag_reg, busy};
            `BWG_IDX_STAT: rdata_next[0] = flag_reg;
            `BWG_IDX_MASK: rdata_next[0] = mask_reg;
            default: rhit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            rresp_reg <= `BWG_RESP_OKAY;
        end else if (s_axi_arvalid && !rvalid_reg) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rdata_next;
            rresp_reg <= rhit ? `BWG_RESP_OKAY : `BWG_RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    // tone timing
    assign tick = ctrl_reg.clk_pick ? tone_tick_fast : tone_tick_slow;
    assign divisor = {ctrl_reg.div_hi, div_lo_reg};
    assign pulse_end = tick && div_cnt_reg == divisor && half_reg;
    assign frame_len = {1'b0, frame_reg[7:4]} + {1'b0, frame_reg[3:0]};
    // a zero-length frame ends after one silent pulse period so a bad setting cannot hang
    assign frame_end = frame_len == 5'h00 ||
        pcount_reg + 5'h01 == frame_len;
    // frame counter wraps to zero on frame 256, matching a total of 0
    assign frame_last = frame_cnt_reg == total_reg;
    assign sess_end = busy && pulse_end && frame_end && frame_last;
    assign sounding = pcount_reg < {1'b0, frame_reg[7:4]};
    assign muted = frame_cnt_reg > mute_reg;
    assign tone_raw = busy && sounding && !muted && !half_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn || !ctrl_reg.on) begin
            state_reg <= bwg_pkg::BWG_IDLE;
            div_cnt_reg <= 9'h000;
            half_reg <= 1'b0;
            pcount_reg <= 5'h00;
            frame_cnt_reg <= `BWG_FIRST_FRAME;
        end else begin
            unique case (state_reg)
                bwg_pkg::BWG_IDLE: begin
                    div_cnt_reg <= 9'h000;
                    half_reg <= 1'b0;
                    pcount_reg <= 5'h00;
                    frame_cnt_reg <= `BWG_FIRST_FRAME;
                    if (launch_reg || ctrl_reg.repeat_on) begin
                        state_reg <= bwg_pkg::BWG_RUN;
                    end
                end
                bwg_pkg::BWG_RUN: begin
                    if (tick) begin
                        if (div_cnt_reg == divisor) begin
                            div_cnt_reg <= 9'h000;
                            half_reg <= !half_reg;
                        end else begin
                            div_cnt_reg <= div_cnt_reg + 9'h001;
                        end
                    end
                    if (pulse_end) begin
                        if (!frame_end) begin
                            pcount_reg <= pcount_reg + 5'h01;
                        end else begin
                            pcount_reg <= 5'h00;
                            frame_cnt_reg <= frame_cnt_reg + 8'h01;
                            if (frame_last) begin
                                frame_cnt_reg <= `BWG_FIRST_FRAME;
                                if (!ctrl_reg.repeat_on) begin
                                    state_reg <= bwg_pkg::BWG_IDLE;
                                end
                            end
                        end
                    end
                end
            endcase
        end
    end

    // idle level follows the inversion bit so the pin never glitches
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tone_out <= 1'b0;
        end else begin
            tone_out <= tone_raw ^ ctrl_reg.inversion;
        end
    end

    tone_half_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        busy && ctrl_reg.on && tick && div_cnt_reg == divisor
        |=> half_reg != $past(half_reg))
        else $error("tone half did not toggle at divider end");

    silent_part_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        busy && pcount_reg >= {1'b0, frame_reg[7:4]}
        |=> tone_out == ctrl_reg.inversion || $past(wr_en))
        else $error("tone sounded in silent part of frame");

    frame_write_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        wr_en && waddr_reg == `BWG_IDX_FRAME
        |=> frame_reg == $past(wdata_reg))
        else $error("frame counts not stored");

    session_length_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        busy && total_reg != 8'h00 |-> frame_cnt_reg <= total_reg)
        else $error("frame index passed the session length");

    launch_start_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        launch_reg && ctrl_reg.on && !busy |=> busy)
        else $error("launch did not start a session");

    single_stop_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        sess_end && !ctrl_reg.repeat_on && ctrl_reg.on |=> !busy)
        else $error("single session did not stop");

    repeat_run_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        sess_end && ctrl_reg.repeat_on && ctrl_reg.on
        |=> busy && frame_cnt_reg == `BWG_FIRST_FRAME)
        else $error("repeat session did not continue");

    done_flag_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        sess_end && ctrl_reg.irq_en |=> flag_reg)
        else $error("session end did not set done flag");

    unit_off_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        !ctrl_reg.on |=> !busy ##1 tone_out == $past(ctrl_reg.inversion))
        else $error("generator ran while off");

    mute_frame_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        busy && frame_cnt_reg > mute_reg
        |=> tone_out == $past(ctrl_reg.inversion))
        else $error("muted frame produced tone");

    busy_read_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && !rvalid_reg && s_axi_araddr[31:2] == `BWG_IDX_CTRL
        |=> s_axi_rdata[0] == $past(busy))
        else $error("control read lost output_active");

    flag_hold_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        flag_reg && !flag_clr |=> flag_reg)
        else $error("done flag dropped without clear");

endmodule

// ### verification/bwg_buzzer_model.sv
/*
 Buzzer pin model: counts rises of the tone and times the last high phase.
 Assumes tone_out is a registered level synchronous to aclk.
*/
`timescale 1ns/100ps
module bwg_buzzer_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic tone_out,
    output logic [15:0] rise_cnt,
    output logic [15:0] high_len
);
    logic prev_reg;
    logic [15:0] run_reg;

    // a piezo only hears edges, so count rises and measure high time
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev_reg <= 1'b0;
            run_reg <= 16'h0000;
            rise_cnt <= 16'h0000;
            high_len <= 16'h0000;
        end else begin
            prev_reg <= tone_out;
            run_reg <= tone_out ? run_reg + 16'h0001 : 16'h0000;
            if (tone_out && !prev_reg) begin
                rise_cnt <= rise_cnt + 16'h0001;
            end
            if (!tone_out && prev_reg) begin
                high_len <= run_reg;
            end
        end
    end
endmodule

// ### verification/test_buzzer_waveform_generator.sv
/*
 Self-checking bench of the buzzer waveform generator.
 Assumes bwg_top and the buzzer pin model; AXI4-Lite master in tasks.
*/
`timescale 1ns/100ps
`include "bwg_map.svh"
module test_buzzer_waveform_generator;
    localparam logic [31:0] A_DIV = {`BWG_IDX_DIV, 2'b00};
    localparam logic [31:0] A_FRM = {`BWG_IDX_FRAME, 2'b00};
    localparam logic [31:0] A_TOT = {`BWG_IDX_TOTAL, 2'b00};
    localparam logic [31:0] A_CTL = {`BWG_IDX_CTRL, 2'b00};
    localparam logic [31:0] A_MUT = {`BWG_IDX_MUTE, 2'b00};
    localparam logic [31:0] A_STA = {`BWG_IDX_STAT, 2'b00};
    localparam logic [31:0] A_MSK = {`BWG_IDX_MASK, 2'b00};
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, tick_slow, tick_fast;
    logic tone_out, irq;
    logic [31:0] awaddr, wdata, araddr, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rsp, tdiv;
    logic [15:0] rise_cnt, high_len, r0;
    int error_cnt = 0;
    int checks = 0;

    bwg_top bwg_top_inst (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .tone_tick_slow(tick_slow), .tone_tick_fast(tick_fast),
        .tone_out(tone_out), .irq(irq));
    bwg_buzzer_model bwg_buzzer_model_inst (.aclk(aclk), .aresetn(aresetn),
        .tone_out(tone_out), .rise_cnt(rise_cnt), .high_len(high_len));

    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    // slow source ticks once in four cycles, fast source every cycle
    always @(posedge aclk) begin
        tdiv <= tdiv + 2'b01;
        tick_slow <= (tdiv == 2'b11);
    end

    task automatic wrap_up;
        $display("errors %0d of %0d checks", error_cnt, checks);
        if (error_cnt == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // bready and rready stay high for the whole run
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic ad, wd;
        ad = 1'b0;
        wd = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge aclk);
            if (awready && !ad) begin
                ad = 1'b1;
                awvalid <= 1'b0;
            end
            if (wready && !wd) begin
                wd = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!bvalid);
        rsp = bresp;
    endtask
    task automatic rdr(input logic [31:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        rd = rdata;
        rsp = rresp;
    endtask
    task automatic wait_idle;
        int n;
        repeat (4) @(posedge aclk);
        n = 0;
        do begin
            rdr(A_CTL);
            n++;
        end while (rd[`BWG_CTRL_LAUNCH] && n < 1000);
        chk(n < 1000, 1'b1);
    endtask
    // sounding plus silent always kept above one
    task automatic session(input logic [7:0] dv, fr, tot, mu, cf);
        wr(A_DIV, dv);
        wr(A_FRM, fr);
        wr(A_TOT, tot);
        wr(A_MUT, mu);
        wr(A_CTL, cf);
        r0 = rise_cnt;
        wr(A_CTL, cf | 8'h01);
        wait_idle();
    endtask

    task automatic s_reset;
        rdr(A_DIV); chk(rd, `BWG_RST_DIV);
        rdr(A_FRM); chk(rd, `BWG_RST_FRAME);
        rdr(A_TOT); chk(rd, `BWG_RST_TOTAL);
        rdr(A_CTL); chk(rd, `BWG_RST_CTRL);
        rdr(A_MUT); chk(rd, `BWG_RST_MUTE);
        rdr(A_STA); chk(rd, 32'h0);
        rdr(A_MSK); chk(rd, 32'h0);
        rdr(32'h000284B4); chk(rsp, `BWG_RESP_SLVERR);
        wr(32'h000284B4, 32'h1); chk(rsp, `BWG_RESP_SLVERR);
        wr(A_DIV, 32'h1A5);
        chk(rsp, `BWG_RESP_OKAY);
        rdr(A_DIV);
        chk(rsp, `BWG_RESP_OKAY);
        chk(rd, 32'hA5);
    endtask
    task automatic s_single;
        wr(A_MSK, 32'h1);
        session(8'h01, 8'h21, 8'h02, 8'hFF, 8'hE0);
        chk(rise_cnt - r0, 16'd4);
        chk(high_len, 16'd2);
        chk(irq, 1'b1);
        rdr(A_CTL); chk(rd[1:0], 2'b10);
        wr(A_STA, 32'h1);
        @(posedge aclk);
        chk(irq, 1'b0);
        rdr(A_CTL); chk(rd[1], 1'b0);
    endtask
    task automatic s_tones;
        session(8'h01, 8'h21, 8'h03, 8'h01, 8'hA0);
        chk(rise_cnt - r0, 16'd2);
        session(8'h00, 8'h11, 8'h01, 8'hFF, 8'hB0);
        chk(high_len, 16'd257);
        // second pulse is whole; the first starts off the slow tick phase
        session(8'h01, 8'h21, 8'h01, 8'hFF, 8'h80);
        chk(rise_cnt - r0, 16'd2);
        chk(high_len, 16'd8);
    endtask
    task automatic s_repeat;
        wr(A_DIV, 8'h01);
        wr(A_FRM, 8'h21);
        wr(A_TOT, 8'h02);
        r0 = rise_cnt;
        wr(A_CTL, 8'hE4);
        repeat (80) @(posedge aclk);
        chk(rise_cnt - r0 > 16'd4, 1'b1);
        rdr(A_STA); chk(rd, 32'h1);
        wr(A_CTL, 8'hA0);
        wait_idle();
        r0 = rise_cnt;
        repeat (50) @(posedge aclk);
        chk(rise_cnt, r0);
        // clear through tone_control bit 1 this time
        wr(A_CTL, 32'h2);
        rdr(A_STA);
        chk(rd, 32'h0);
    endtask
    task automatic s_disable;
        wr(A_CTL, 8'hA8);
        wr(A_CTL, 8'hA9);
        repeat (6) @(posedge aclk);
        wr(A_CTL, 8'h08);
        repeat (2) @(posedge aclk);
        chk(tone_out, 1'b1);
        wr(A_CTL, 8'h09);
        repeat (4) @(posedge aclk);
        rdr(A_CTL); chk(rd[0], 1'b0);
    endtask

    initial begin
        aresetn = 1'b0;
        {awvalid, wvalid, arvalid, tick_slow} = 4'h0;
        {awaddr, wdata, araddr} = '0;
        wstrb = 4'hF;
        tdiv = 2'b00;
        bready = 1'b1;
        rready = 1'b1;
        tick_fast = 1'b1;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        s_reset();
        s_single();
        s_tones();
        s_repeat();
        s_disable();
        wrap_up();
    end
    initial begin
        repeat (40000) @(posedge aclk);
        error_cnt++;
        wrap_up();
    end
endmodule
